// File: verilog/edc_defines.svh
// Constants for the endpoint descriptor checker
//
// Functional notes
// - Control endpoint maximum packet size must be exactly 512
// - Bulk endpoint maximum packet size must be exactly 1024
// - Interrupt or isochronous with nonzero burst needs packet size 1024
// - Zero burst: isochronous 0..1024, interrupt 1..1024
// - Interval field counts in 125 microsecond units
// - Service period equals two to the power interval minus one
// - Periodic endpoints need interval 1..16
// - Notification interrupt endpoints need interval 8..16
// - Bulk and control interval is reserved; no period derived
// - Attribute byte: transfer 1..0, sync 3..2, usage 5..4
// - Interrupt usage 01b notification, 00b periodic, others flagged
// - Isochronous usage 00b data, 01b explicit feedback
// - Isochronous usage 10b is data plus implicit feedback
// - Explicit feedback must be isochronous with no synchronization
// - Feedback endpoint direction opposite to data endpoints served
// - Data endpoints sharing feedback use ascending numbers
// - First data endpoint shares number with its feedback endpoint
// - Data finds feedback as first one numbered at or below
// - Address bit 7 is direction, 1 means IN, ignored for control
`ifndef EDC_DEFINES_SVH
`define EDC_DEFINES_SVH

`define EDC_MPS_CTRL    16'h0200
`define EDC_MPS_MAX     16'h0400
`define EDC_IV_MIN      8'h01
`define EDC_IV_MAX      8'h10
`define EDC_IV_NOTE_MIN 8'h08
`define EDC_UNIT_US     125

`define EDC_UT_PERIODIC 2'h0
`define EDC_UT_NOTIFY   2'h1
`define EDC_UT_DATA     2'h0
`define EDC_UT_EFB      2'h1
`define EDC_UT_IFB      2'h2
`define EDC_UT_RSVD     2'h3

`define EDC_A_CTRL 4'h0
`define EDC_A_STAT 4'h1
`define EDC_A_PER  4'h2
`define EDC_A_MASK 4'h3
`define EDC_A_LAST 4'h4

`define EDC_C_CLR 0
`define EDC_C_TBL 1
`define EDC_C_CHK 2

`define EDC_NFLAG     12
`define EDC_MASK_RST  12'hfff
`define EDC_F_CTRL    0
`define EDC_F_BULK    1
`define EDC_F_BURST   2
`define EDC_F_ZERO    3
`define EDC_F_IVRANGE 4
`define EDC_F_IVNOTE  5
`define EDC_F_INTUSE  6
`define EDC_F_ISOUSE  7
`define EDC_F_EFB     8
`define EDC_F_DIR     9
`define EDC_F_ORDER   10
`define EDC_F_FIRST   11

`endif

// File: verilog/edc_pkg.sv
// Types shared by the endpoint descriptor checker
package edc_pkg;

  typedef enum logic [1:0] {
    EDC_XF_CTRL = 2'h0,
    EDC_XF_ISO  = 2'h1,
    EDC_XF_BULK = 2'h2,
    EDC_XF_INT  = 2'h3
  } edc_xfer_t;

  typedef enum logic [1:0] {
    EDC_SY_NONE  = 2'h0,
    EDC_SY_ASYNC = 2'h1,
    EDC_SY_ADAPT = 2'h2,
    EDC_SY_SYNC  = 2'h3
  } edc_sync_t;

endpackage

// File: verilog/edc_fb_table.sv
// Feedback group table and association scan
`timescale 1ns/100ps
module edc_fb_table #(
  parameter int NUM_EP = 16
) (
  input  wire logic       mclk_in,       // System clock
  input  wire logic       resetn_in,     // Sync reset, low
  input  wire logic       clear_in,      // Empty the table
  input  wire logic       rec_in,        // Record one endpoint
  input  wire logic [3:0] num_in,        // Endpoint number
  input  wire logic       dir_in,        // 1 = IN
  input  wire logic       data_in,       // Data needing feedback
  input  wire logic       fb_in,         // Feedback endpoint
  output logic            dir_bad_out,   // Wrong direction found
  output logic            first_bad_out, // Group start mismatch
  output logic            order_bad_out  // Pulse: not ascending
);

  logic [1:0][NUM_EP-1:0] data_reg;
  logic [1:0][NUM_EP-1:0] fb_reg;
  logic [1:0][3:0]        last_reg;
  logic [1:0]             seen_reg;
  logic                   dir_bad_next;
  logic                   first_bad_next;
  logic                   hit_opp;
  logic                   hit_same;
  int                     best;

  // Search downward for the nearest feedback of each data endpoint
  always_comb begin
    dir_bad_next   = 1'b0;
    first_bad_next = 1'b0;
    hit_opp        = 1'b0;
    hit_same       = 1'b0;
    best           = 0;
    for (int d = 0; d < 2; d++) begin
      for (int n = 0; n < NUM_EP; n++) begin
        hit_opp  = 1'b0;
        hit_same = 1'b0;
        best     = 0;
        for (int m = 0; m <= n; m++) begin
          if (fb_reg[1-d][m]) begin
            hit_opp = 1'b1;
            best    = m;
          end
          if (fb_reg[d][m])
            hit_same = 1'b1;
        end
        if (data_reg[d][n]) begin
          if (!hit_opp && hit_same)
            dir_bad_next = 1'b1;
          if (!hit_opp || !data_reg[d][best])
            first_bad_next = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in || clear_in) begin
      data_reg      <= '0;
      fb_reg        <= '0;
      last_reg      <= '0;
      seen_reg      <= 2'h0;
      order_bad_out <= 1'b0;
    end else begin
      order_bad_out <= rec_in && data_in && seen_reg[dir_in]
                       && (num_in <= last_reg[dir_in]);
      if (rec_in && data_in) begin
        data_reg[dir_in][num_in] <= 1'b1;
        last_reg[dir_in]         <= num_in;
        seen_reg[dir_in]         <= 1'b1;
      end
      if (rec_in && fb_in)
        fb_reg[dir_in][num_in] <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      dir_bad_out   <= 1'b0;
      first_bad_out <= 1'b0;
    end else begin
      dir_bad_out   <= dir_bad_next;
      first_bad_out <= first_bad_next;
    end
  end

endmodule // edc_fb_table

// File: verilog/edc_checker.sv
// Endpoint descriptor checker: field checks, period decode, registers
`timescale 1ns/100ps
`include "edc_defines.svh"
module edc_checker #(
  parameter int NUM_EP = 16
) (
  input  wire logic        mclk_in,          // System clock, 10 MHz
  input  wire logic        resetn_in,        // Sync reset, low
  input  wire logic        desc_valid_in,    // Descriptor fields valid
  input  wire logic [7:0]  ep_addr_in,       // Endpoint address byte
  input  wire logic [7:0]  attr_in,          // Attribute byte
  input  wire logic [15:0] max_pkt_in,       // Maximum packet size
  input  wire logic [7:0]  interval_in,      // Service interval field
  input  wire logic [3:0]  max_burst_in,     // Burst count
  input  wire logic [3:0]  reg_addr_in,      // Register address
  input  wire logic [31:0] reg_wdata_in,     // Register write data
  input  wire logic        reg_wr_in,        // Write strobe
  input  wire logic        reg_rd_in,        // Read strobe
  output logic      [31:0] reg_rdata_out,    // Read data, next cycle
  output logic             err_out,          // Any flag set
  output logic      [11:0] flags_out,        // Sticky flags
  output logic      [15:0] period_out,       // Period, 125 us units
  output logic             period_valid_out  // Period is derived
);

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  function automatic logic [1:0] f_field(input logic [7:0] b,
                                         input int lsb);
    f_field = b[lsb+:2];
  endfunction

  function automatic logic f_in(input logic [15:0] v,
                                input logic [15:0] lo,
                                input logic [15:0] hi);
    f_in = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [15:0] f_period(input logic [7:0] iv);
    logic [7:0] sh;
    sh       = iv - 8'h01;
    f_period = 16'h0001 << sh[3:0];
  endfunction

  wire logic [1:0] tt_w  = f_field(attr_in, 0);
  wire logic [1:0] st_w  = f_field(attr_in, 2);
  wire logic [1:0] ut_w  = f_field(attr_in, 4);
  wire logic       dir_w = ep_addr_in[7];
  wire logic [3:0] num_w = ep_addr_in[3:0];
  wire logic [15:0] iv_w = {8'h00, interval_in};

  wire logic is_ctrl_w = tt_w == edc_pkg::EDC_XF_CTRL;
  wire logic is_iso_w  = tt_w == edc_pkg::EDC_XF_ISO;
  wire logic is_bulk_w = tt_w == edc_pkg::EDC_XF_BULK;
  wire logic is_int_w  = tt_w == edc_pkg::EDC_XF_INT;
  wire logic periodic_w = is_iso_w || is_int_w;
  wire logic burst_w    = max_burst_in != 4'h0;

  wire logic iv_ok_w = f_in(iv_w, {8'h00, `EDC_IV_MIN},
                            {8'h00, `EDC_IV_MAX});
  wire logic iv_note_ok_w = f_in(iv_w, {8'h00, `EDC_IV_NOTE_MIN},
                                 {8'h00, `EDC_IV_MAX});
  wire logic mps_le_max_w = f_in(max_pkt_in, 16'h0000, `EDC_MPS_MAX);
  wire logic mps_int_ok_w = f_in(max_pkt_in, 16'h0001, `EDC_MPS_MAX);

  wire logic notify_w = is_int_w && (ut_w == `EDC_UT_NOTIFY);
  wire logic efb_w    = is_iso_w && (ut_w == `EDC_UT_EFB);
  wire logic ifb_w    = is_iso_w && (ut_w == `EDC_UT_IFB);

  // ----------------------------------------------------------------
  // Per-descriptor checks
  // ----------------------------------------------------------------
  wire logic bad_ctrl_w  = is_ctrl_w
                           && (max_pkt_in != `EDC_MPS_CTRL);
  wire logic bad_bulk_w  = is_bulk_w
                           && (max_pkt_in != `EDC_MPS_MAX);
  wire logic bad_burst_w = periodic_w && burst_w
                           && (max_pkt_in != `EDC_MPS_MAX);
  wire logic bad_zero_w  = !burst_w
                           && ((is_iso_w && !mps_le_max_w)
                           || (is_int_w && !mps_int_ok_w));
  wire logic bad_iv_w    = periodic_w && !iv_ok_w;
  wire logic bad_note_w  = notify_w && !iv_note_ok_w;
  wire logic bad_intu_w  = is_int_w && ut_w[1];
  wire logic bad_isou_w  = is_iso_w
                           && (ut_w == `EDC_UT_RSVD);
  wire logic bad_efb_w   = efb_w
                           && (st_w != edc_pkg::EDC_SY_NONE);

  // Data endpoints that rely on a feedback endpoint
  wire logic need_fb_w = is_iso_w && (ut_w == `EDC_UT_DATA)
                         && (((st_w == edc_pkg::EDC_SY_ASYNC) && !dir_w)
                         || ((st_w == edc_pkg::EDC_SY_ADAPT) && dir_w));

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire logic wr_ctrl_w = reg_wr_in && (reg_addr_in == `EDC_A_CTRL);
  wire logic wr_mask_w = reg_wr_in && (reg_addr_in == `EDC_A_MASK);
  wire logic clr_w = wr_ctrl_w && reg_wdata_in[`EDC_C_CLR];
  wire logic tbl_w = wr_ctrl_w && reg_wdata_in[`EDC_C_TBL];
  wire logic chk_w = wr_ctrl_w && reg_wdata_in[`EDC_C_CHK];

  logic [11:0] flags_reg;
  logic [11:0] flags_next;
  logic [11:0] mask_reg;
  logic [11:0] set_w;
  logic [15:0] period_reg;
  logic [15:0] period_next;
  logic        pvalid_reg;
  logic        pvalid_next;
  logic [10:0] last_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux_w;
  logic        chk_reg;
  logic        tb_dir_bad;
  logic        tb_first_bad;
  logic        tb_order_bad;

  // ----------------------------------------------------------------
  // Feedback group table
  // ----------------------------------------------------------------
  edc_fb_table #(
    .NUM_EP (NUM_EP)
  ) u_fb_table (
    .mclk_in       (mclk_in),
    .resetn_in     (resetn_in),
    .clear_in      (tbl_w),
    .rec_in        (desc_valid_in),
    .num_in        (num_w),
    .dir_in        (dir_w),
    .data_in       (need_fb_w),
    .fb_in         (efb_w || ifb_w),
    .dir_bad_out   (tb_dir_bad),
    .first_bad_out (tb_first_bad),
    .order_bad_out (tb_order_bad)
  );

  // ----------------------------------------------------------------
  // Sticky flags, set wins over clear
  // ----------------------------------------------------------------
  wire logic [11:0] desc_set_w = {3'h0, bad_efb_w, bad_isou_w,
                                  bad_intu_w, bad_note_w, bad_iv_w,
                                  bad_zero_w, bad_burst_w, bad_bulk_w,
                                  bad_ctrl_w};

  // Group scan result is taken a cycle after the check strobe
  assign set_w = ({12{desc_valid_in}} & desc_set_w)
               | ({11'h000, chk_reg && tb_dir_bad} << `EDC_F_DIR)
               | ({11'h000, chk_reg && tb_first_bad} << `EDC_F_FIRST)
               | ({11'h000, tb_order_bad} << `EDC_F_ORDER);

  assign flags_next = (flags_reg & ~{12{clr_w}})
                    | (set_w & mask_reg);

  // ----------------------------------------------------------------
  // Period decode
  // ----------------------------------------------------------------
  assign pvalid_next = desc_valid_in ? (periodic_w && iv_ok_w)
                                     : pvalid_reg;
  assign period_next = !desc_valid_in ? period_reg
                     : (periodic_w && iv_ok_w) ? f_period(interval_in)
                     : 16'h0000;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  assign rd_mux_w = (reg_addr_in == `EDC_A_STAT) ? {20'h0, flags_reg}
                  : (reg_addr_in == `EDC_A_PER)
                    ? {15'h0, pvalid_reg, period_reg}
                  : (reg_addr_in == `EDC_A_MASK) ? {20'h0, mask_reg}
                  : (reg_addr_in == `EDC_A_LAST) ? {21'h0, last_reg}
                  : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      flags_reg  <= 12'h000;
      period_reg <= 16'h0000;
      pvalid_reg <= 1'b0;
      chk_reg    <= 1'b0;
    end else begin
      flags_reg  <= flags_next;
      period_reg <= period_next;
      pvalid_reg <= pvalid_next;
      chk_reg    <= chk_w;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in)
      mask_reg <= `EDC_MASK_RST;
    else if (wr_mask_w)
      mask_reg <= reg_wdata_in[11:0];
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in)
      last_reg <= 11'h000;
    else if (desc_valid_in)
      last_reg <= {dir_w, num_w, ut_w, st_w, tt_w};
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in)
      rdata_reg <= 32'h0000_0000;
    else
      rdata_reg <= reg_rd_in ? rd_mux_w : 32'h0000_0000;
  end

  assign reg_rdata_out    = rdata_reg;
  assign flags_out        = flags_reg;
  assign err_out          = |flags_reg;
  assign period_out       = period_reg;
  assign period_valid_out = pvalid_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);

  a_ctrl_size: assert property (
    desc_valid_in && bad_ctrl_w && mask_reg[`EDC_F_CTRL]
    |=> flags_reg[`EDC_F_CTRL])
    else $error("control packet size not flagged");

  a_bulk_size: assert property (
    desc_valid_in && is_bulk_w && (max_pkt_in != 16'h0400)
    && mask_reg[`EDC_F_BULK] |=> flags_reg[`EDC_F_BULK])
    else $error("bulk packet size not flagged");

  a_burst_size: assert property (
    desc_valid_in && periodic_w && burst_w && !flags_reg[`EDC_F_BURST]
    && (max_pkt_in == 16'h0400) && !tb_order_bad
    |=> !flags_reg[`EDC_F_BURST])
    else $error("good burst packet size flagged");

  a_zero_burst: assert property (
    desc_valid_in && is_int_w && !burst_w && (max_pkt_in == 16'h0000)
    && mask_reg[`EDC_F_ZERO] |=> flags_reg[`EDC_F_ZERO])
    else $error("zero interrupt packet size not flagged");

  a_period_val: assert property (
    desc_valid_in && periodic_w && (interval_in == 8'h04)
    |=> (period_out == 16'h0008) && period_valid_out)
    else $error("period decode wrong");

  a_no_period: assert property (
    desc_valid_in && (is_bulk_w || is_ctrl_w)
    |=> !period_valid_out ##0 (period_out == 16'h0000))
    else $error("period derived for bulk or control");

  a_iv_range: assert property (
    desc_valid_in && periodic_w && (interval_in == 8'h11)
    && mask_reg[`EDC_F_IVRANGE] |=> flags_reg[`EDC_F_IVRANGE])
    else $error("interval range not flagged");

  a_note_range: assert property (
    desc_valid_in && notify_w && (interval_in == 8'h07)
    && mask_reg[`EDC_F_IVNOTE] |=> flags_reg[`EDC_F_IVNOTE])
    else $error("notification interval not flagged");

  a_efb_sync: assert property (
    desc_valid_in && efb_w && (st_w != 2'h0) && mask_reg[`EDC_F_EFB]
    |=> flags_reg[`EDC_F_EFB])
    else $error("feedback sync type not flagged");

  a_flag_sticky: assert property (
    flags_reg[`EDC_F_CTRL] && !clr_w [*2]
    |=> flags_reg[`EDC_F_CTRL])
    else $error("flag dropped without clear");

  a_clear_flags: assert property (
    clr_w && !desc_valid_in && !chk_reg && !tb_order_bad
    |=> (flags_reg == 12'h000) && !err_out)
    else $error("clear strobe failed");

  a_read_late: assert property (
    reg_rd_in && (reg_addr_in == `EDC_A_STAT)
    |=> reg_rdata_out == {20'h0, $past(flags_reg)} ##1
        reg_rdata_out == 32'h0 || $past(reg_rd_in))
    else $error("read data timing wrong");

  a_int_usage: assert property (
    desc_valid_in && is_int_w && ut_w[1] && mask_reg[`EDC_F_INTUSE]
    |=> flags_reg[`EDC_F_INTUSE])
    else $error("reserved interrupt usage not flagged");

  a_iso_usage: assert property (
    desc_valid_in && is_iso_w && (ut_w == 2'h3) && mask_reg[`EDC_F_ISOUSE]
    |=> flags_reg[`EDC_F_ISOUSE])
    else $error("reserved isochronous usage not flagged");

  a_iso_zero: assert property (
    desc_valid_in && is_iso_w && !burst_w && (max_pkt_in == 16'h0401)
    && mask_reg[`EDC_F_ZERO] |=> flags_reg[`EDC_F_ZERO])
    else $error("oversize isochronous packet not flagged");

  a_order_flag: assert property (
    tb_order_bad && mask_reg[`EDC_F_ORDER]
    |=> flags_reg[`EDC_F_ORDER])
    else $error("descending data endpoint not flagged");

  a_group_dir: assert property (
    chk_reg && tb_dir_bad && mask_reg[`EDC_F_DIR]
    |=> flags_reg[`EDC_F_DIR])
    else $error("feedback direction not flagged");

  a_group_first: assert property (
    chk_reg && tb_first_bad && mask_reg[`EDC_F_FIRST]
    |=> flags_reg[`EDC_F_FIRST])
    else $error("group start mismatch not flagged");

  a_last_fields: assert property (
    desc_valid_in |=> last_reg == {$past(ep_addr_in[7]),
                                   $past(ep_addr_in[3:0]),
                                   $past(attr_in[5:0])})
    else $error("recorded fields wrong");

  a_period_max: assert property (
    desc_valid_in && periodic_w && (interval_in == 8'h10)
    |=> (period_out == 16'h8000) && period_valid_out)
    else $error("longest period decode wrong");

  a_period_none: assert property (
    desc_valid_in && periodic_w && (interval_in == 8'h00)
    |=> !period_valid_out && (period_out == 16'h0000))
    else $error("period derived from bad interval");

  a_period_hold: assert property (
    !desc_valid_in |=> $stable(period_out) && $stable(period_valid_out))
    else $error("period changed without descriptor");

  a_mask_gate: assert property (
    desc_valid_in && bad_ctrl_w && !mask_reg[`EDC_F_CTRL]
    && !flags_reg[`EDC_F_CTRL] && !clr_w |=> !flags_reg[`EDC_F_CTRL])
    else $error("masked flag was set");

  a_rd_idle: assert property (
    !reg_rd_in
    |=> reg_rdata_out == 32'h0000_0000)
    else $error("read data stands too long");

  c_ctrl_bad: cover property (desc_valid_in && bad_ctrl_w);
  c_period16: cover property (desc_valid_in && periodic_w
                              && (interval_in == 8'h10));
  c_group_chk: cover property (chk_reg && tb_first_bad);
  c_clear_set: cover property (clr_w && desc_valid_in
                               && (desc_set_w != 12'h000));
  c_order_bad: cover property (tb_order_bad);

endmodule // edc_checker

// File: sim/edc_desc_src.sv
// Descriptor feed model: presents endpoint descriptors as the host reads them
`timescale 1ns/100ps
module edc_desc_src (
  input  wire logic        mclk_in,        // System clock
  output logic             desc_valid_out, // One-cycle descriptor strobe
  output logic [7:0]       ep_addr_out,    // Endpoint address byte
  output logic [7:0]       attr_out,       // Attribute byte
  output logic [15:0]      max_pkt_out,    // Maximum packet size
  output logic [7:0]       interval_out,   // Service interval field
  output logic [3:0]       max_burst_out   // Burst count
);
  initial begin
    desc_valid_out = 1'b0;
    ep_addr_out    = 8'h00;
    attr_out       = 8'h00;
    max_pkt_out    = 16'h0000;
    interval_out   = 8'h00;
    max_burst_out  = 4'h0;
  end

  // ----------------------------------------
  // One descriptor, fields scrambled after
  // ----------------------------------------
  task automatic send(input logic dir, input logic [3:0] num, input logic [1:0] xf,
                      input logic [1:0] sy, input logic [1:0] ut, input logic [15:0] mps,
                      input logic [7:0] iv, input logic [3:0] burst);
    @(posedge mclk_in);
    desc_valid_out <= 1'b1;
    ep_addr_out    <= {dir, 3'h0, num};
    attr_out       <= {2'h0, ut, sy, xf};
    max_pkt_out    <= mps;
    interval_out   <= iv;
    max_burst_out  <= burst;
    @(posedge mclk_in);
    desc_valid_out <= 1'b0;
    ep_addr_out    <= ~{dir, 3'h0, num};
    attr_out       <= ~{2'h0, ut, sy, xf};
    max_pkt_out    <= ~mps;
    interval_out   <= ~iv;
    max_burst_out  <= ~burst;
  endtask
endmodule // edc_desc_src

// File: sim/edc_checker_tb.sv
// Self-checking testbench for the endpoint descriptor checker
`timescale 1ns/100ps
module edc_checker_tb;
  logic        mclk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        desc_valid, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [7:0]  ep_addr, attr, interval;
  logic [15:0] max_pkt, period_out;
  logic [3:0]  max_burst, reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
  logic        err_out, period_valid_out;
  logic [11:0] flags_out;
  int          num_errors = 0;
  int          checked = 0;

  always #50 mclk_in = ~mclk_in;

  edc_desc_src src (.mclk_in(mclk_in), .desc_valid_out(desc_valid), .ep_addr_out(ep_addr),
    .attr_out(attr), .max_pkt_out(max_pkt), .interval_out(interval),
    .max_burst_out(max_burst));

  edc_checker #(.NUM_EP(16)) dut (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .desc_valid_in(desc_valid), .ep_addr_in(ep_addr), .attr_in(attr),
    .max_pkt_in(max_pkt), .interval_in(interval), .max_burst_in(max_burst),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .err_out(err_out),
    .flags_out(flags_out), .period_out(period_out), .period_valid_out(period_valid_out));

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
    @(posedge mclk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in   <= 1'b0;
    #1;
    chk(nm, reg_rdata_out, exp);
  endtask

  task automatic dsc(input logic dir, input logic [3:0] num, input logic [1:0] xf,
                     input logic [1:0] sy, input logic [1:0] ut, input logic [15:0] mps,
                     input logic [7:0] iv, input logic [3:0] burst);
    src.send(dir, num, xf, sy, ut, mps, iv, burst);
    repeat (3) @(posedge mclk_in);
    #1;
  endtask

  task automatic fl(input logic [11:0] exp);
    chk("flags", {20'h0, flags_out}, {20'h0, exp});
    chk("error", {31'h0, err_out}, {31'h0, exp != 12'h000});
  endtask

  task automatic per(input logic v, input logic [15:0] p);
    chk("period valid", {31'h0, period_valid_out}, {31'h0, v});
    chk("period", {16'h0, period_out}, {16'h0, p});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(4'h3, 32'h0000_0fff, "mask reset");
    rd(4'h1, 32'h0, "stat reset");
    fl(12'h000);
    per(1'b0, 16'h0000);
  endtask

  task automatic t_size();
    dsc(0, 1, edc_pkg::EDC_XF_CTRL, 0, 0, 16'h0200, 0, 0); fl(12'h000);
    dsc(0, 1, edc_pkg::EDC_XF_CTRL, 0, 0, 16'h0201, 0, 0); fl(12'h001);
    dsc(1, 2, edc_pkg::EDC_XF_BULK, 0, 0, 16'h0400, 0, 0); fl(12'h001);
    rd(4'h1, 32'h1, "stat");
    wr(4'h0, 32'h1);
    dsc(1, 2, edc_pkg::EDC_XF_BULK, 0, 0, 16'h03ff, 0, 3); fl(12'h002);
    wr(4'h0, 32'h1);
    dsc(1, 3, edc_pkg::EDC_XF_ISO, 0, 0, 16'h03e8, 1, 1); fl(12'h004);
    wr(4'h0, 32'h1);
    dsc(1, 3, edc_pkg::EDC_XF_ISO, 0, 0, 16'h0400, 1, 2); fl(12'h000);
    dsc(1, 3, edc_pkg::EDC_XF_ISO, 0, 0, 16'h0000, 1, 0); fl(12'h000);
    dsc(1, 3, edc_pkg::EDC_XF_ISO, 0, 0, 16'h0401, 1, 0); fl(12'h008);
    wr(4'h0, 32'h1);
    dsc(1, 5, edc_pkg::EDC_XF_INT, 0, 0, 16'h0000, 1, 0); fl(12'h008);
    wr(4'h0, 32'h1);
    dsc(1, 5, edc_pkg::EDC_XF_INT, 0, 0, 16'h0400, 1, 0); fl(12'h000);
  endtask

  task automatic t_interval();
    dsc(1, 5, edc_pkg::EDC_XF_INT, 0, 0, 16'h0040, 8'h04, 0); per(1, 16'h0008);
    rd(4'h2, 32'h0001_0008, "period reg");
    dsc(1, 5, edc_pkg::EDC_XF_INT, 0, 0, 16'h0040, 8'h10, 0); per(1, 16'h8000);
    dsc(1, 5, edc_pkg::EDC_XF_INT, 0, 0, 16'h0040, 8'h00, 0); per(0, 16'h0000);
    fl(12'h010);
    wr(4'h0, 32'h1);
    dsc(1, 5, edc_pkg::EDC_XF_INT, 0, 0, 16'h0040, 8'h11, 0); fl(12'h010);
    wr(4'h0, 32'h1);
    dsc(1, 5, edc_pkg::EDC_XF_INT, 0, 1, 16'h0040, 8'h07, 0); fl(12'h020);
    wr(4'h0, 32'h1);
    dsc(1, 5, edc_pkg::EDC_XF_INT, 0, 1, 16'h0040, 8'h08, 0); fl(12'h000);
    dsc(1, 2, edc_pkg::EDC_XF_BULK, 0, 0, 16'h0400, 8'h04, 0); per(0, 16'h0000);
    dsc(0, 2, edc_pkg::EDC_XF_BULK, 0, 0, 16'h0400, 8'hff, 0); per(0, 16'h0000);
    fl(12'h000);
    dsc(1, 5, edc_pkg::EDC_XF_INT, 0, 2, 16'h0040, 8'h04, 0); fl(12'h040);
    wr(4'h0, 32'h1);
    dsc(1, 6, edc_pkg::EDC_XF_ISO, 0, 3, 16'h0040, 8'h04, 0); fl(12'h080);
    wr(4'h0, 32'h1);
    dsc(1, 6, edc_pkg::EDC_XF_ISO, 1, 1, 16'h0004, 8'h04, 0); fl(12'h100);
    wr(4'h0, 32'h1);
  endtask

  task automatic t_group();
    wr(4'h0, 32'h3);
    dsc(1, 1, edc_pkg::EDC_XF_ISO, 0, 1, 16'h0004, 1, 0);
    dsc(0, 1, edc_pkg::EDC_XF_ISO, 1, 0, 16'h0100, 1, 0);
    dsc(0, 3, edc_pkg::EDC_XF_ISO, 1, 0, 16'h0100, 1, 0);
    wr(4'h0, 32'h4);
    repeat (3) @(posedge mclk_in);
    #1;
    fl(12'h000);
    dsc(0, 2, edc_pkg::EDC_XF_ISO, 1, 0, 16'h0100, 1, 0); fl(12'h400);
    wr(4'h0, 32'h3);
    dsc(0, 4, edc_pkg::EDC_XF_ISO, 0, 2, 16'h0004, 1, 0);
    dsc(0, 4, edc_pkg::EDC_XF_ISO, 1, 0, 16'h0100, 1, 0);
    rd(4'h4, 32'h0000_0105, "last fields");
    wr(4'h0, 32'h4);
    repeat (3) @(posedge mclk_in);
    #1;
    fl(12'ha00);
    wr(4'h0, 32'h3);
  endtask

  task automatic t_mask();
    wr(4'h3, 32'h0000_0ffe);
    rd(4'h3, 32'h0000_0ffe, "mask");
    dsc(0, 1, edc_pkg::EDC_XF_CTRL, 0, 0, 16'h0201, 0, 0); fl(12'h000);
    wr(4'h1, 32'h0000_0fff);
    rd(4'h1, 32'h0, "stat read only");
    rd(4'hf, 32'h0, "unmapped");
    wr(4'h3, 32'h0000_0fff);
  endtask

  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #500000;
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge mclk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_size();
    t_interval();
    t_group();
    t_mask();
    end_of_test();
  end
endmodule // edc_checker_tb
